/* rtl/bss_pkg.sv */
package bss_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [23:0] BSS_OFF_DATA_LEGACY = 24'h001380;
    localparam logic [23:0] BSS_OFF_CTRL_LEGACY = 24'h001384;
    localparam logic [23:0] BSS_OFF_SETUP_LEGACY = 24'h001388;
    localparam logic [23:0] BSS_OFF_TOP_LEGACY = 24'h00138C;
    localparam logic [23:0] BSS_OFF_DATA = 24'h619E40;
    localparam logic [23:0] BSS_OFF_CTRL = 24'h619E44;
    localparam logic [23:0] BSS_OFF_SETUP = 24'h619E48;
    localparam logic [23:0] BSS_OFF_TOP = 24'h619E4C;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BSS_SETUP_PUSH_AUTO = 0;
    localparam int BSS_SETUP_POP_AUTO = 1;
    localparam int BSS_SETUP_READ_FIRST = 2;
    localparam int BSS_SETUP_OVF_CLR = 6;
    localparam int BSS_SETUP_UNF_CLR = 7;
    localparam int BSS_CTRL_PUSH = 0;
    localparam int BSS_CTRL_POP = 1;
    localparam int BSS_CTRL_EMPTY = 4;
    localparam int BSS_CTRL_FULL = 5;
    localparam int BSS_CTRL_OVF = 6;
    localparam int BSS_CTRL_UNF = 7;
    // ----------------------------------------------------------------
    // sizes and reset values
    // ----------------------------------------------------------------
    localparam int BSS_IDX_W = 10;
    localparam int BSS_ADDR_W = 9;
    localparam int BSS_DEPTH = 512;
    localparam logic [9:0] BSS_FULL_IDX = 10'h200;
    localparam logic [9:0] BSS_IDX_ZERO = 10'h000;
    localparam logic [9:0] BSS_IDX_ONE = 10'h001;
    localparam logic [2:0] BSS_SETUP_RST = 3'h0;
    localparam logic [7:0] BSS_BYTE_ZERO = 8'h00;
endpackage

/* rtl/bss_stack.sv */
// Functional notes
// - setup bit0: push manual or every write
// - setup bit1: pop manual or every read
// - setup bit2: manual pop order select
// - legacy: setup bit6 clears overflow, reads zero
// - legacy: setup bit7 clears underflow, reads zero
// - top index readable, writable, ten bits
// - data write: legacy stores, newer shadows
// - auto-pop read returns the cell below top, then pops; newer at index zero returns the pop shadow and does not pop
// - legacy read at zero flags underflow
// - newer manual read: shadow or cell below
// - newer faulting push/pop sets its flag, leaves index and cells
// - newer pop clears overflow, push underflow, unless the other one is refused that cycle
// - legacy push, else pop, always moves, wrapping
// - control bits 0/1 strobe push/pop, read zero
`timescale 1ns/1ps
`default_nettype none
module bss_stack
    import bss_pkg::*;
#(
    parameter bit NEWER = 1'b1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [23:0] addr_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out,
    output logic rvalid_out
);
    // ----------------------------------------------------------------
    // storage and state
    // ----------------------------------------------------------------
    logic [7:0] cells_r [BSS_DEPTH];
    logic [9:0] top_r;
    logic [2:0] setup_r;
    logic ovf_r;
    logic unf_r;
    logic [7:0] push_shadow_r;
    logic [7:0] pop_shadow_r;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [23:0] a, input logic [23:0] o_new,
                                 input logic [23:0] o_old);
        hit = NEWER ? (a == o_new) : (a == o_old);
    endfunction

    logic sel_data, sel_ctrl, sel_setup, sel_top;
    assign sel_data = hit(addr_in, BSS_OFF_DATA, BSS_OFF_DATA_LEGACY);
    assign sel_ctrl = hit(addr_in, BSS_OFF_CTRL, BSS_OFF_CTRL_LEGACY);
    assign sel_setup = hit(addr_in, BSS_OFF_SETUP, BSS_OFF_SETUP_LEGACY);
    assign sel_top = hit(addr_in, BSS_OFF_TOP, BSS_OFF_TOP_LEGACY);

    logic push_auto, pop_auto, read_first;
    assign push_auto = setup_r[BSS_SETUP_PUSH_AUTO];
    assign pop_auto = setup_r[BSS_SETUP_POP_AUTO];
    assign read_first = setup_r[BSS_SETUP_READ_FIRST];

    // push and pop events
    logic do_push, do_pop, data_wr, data_rd;
    assign data_wr = wr_in && sel_data;
    assign data_rd = rd_in && sel_data;
    assign do_push = (data_wr && push_auto) || (wr_in && sel_ctrl && wdata_in[BSS_CTRL_PUSH]);
    assign do_pop = (data_rd && pop_auto) || (wr_in && sel_ctrl && wdata_in[BSS_CTRL_POP]);

    logic is_full, is_empty;
    assign is_full = top_r >= BSS_FULL_IDX;
    assign is_empty = top_r == BSS_IDX_ZERO;

    logic [8:0] a_top, a_below;
    assign a_top = top_r[BSS_ADDR_W-1:0];
    assign a_below = a_top - 9'h001;

    // ----------------------------------------------------------------
    // setup register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            setup_r <= BSS_SETUP_RST;
        end else if (wr_in && sel_setup) begin
            setup_r <= wdata_in[2:0];
        end
    end

    // ----------------------------------------------------------------
    // top index
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            top_r <= BSS_IDX_ZERO;
        end else if (wr_in && sel_top) begin
            top_r <= wdata_in[BSS_IDX_W-1:0];
        end else if (!NEWER) begin
            if (do_push) top_r <= top_r + BSS_IDX_ONE;
            else if (do_pop) top_r <= top_r - BSS_IDX_ONE;
        end else begin
            if (do_push && !is_full) top_r <= top_r + BSS_IDX_ONE;
            else if (do_pop && !is_empty) top_r <= top_r - BSS_IDX_ONE;
        end
    end

    // ----------------------------------------------------------------
    // cell array and shadows
    // ----------------------------------------------------------------
    // newer auto push writes the fresh byte, not the stale shadow
    logic [7:0] push_byte;
    assign push_byte = data_wr ? wdata_in[7:0] : push_shadow_r;

    always_ff @(posedge clk_in) begin
        if (!NEWER && data_wr) begin
            cells_r[a_top] <= wdata_in[7:0];
        end else if (NEWER && do_push && !is_full) begin
            cells_r[a_top] <= push_byte;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            push_shadow_r <= BSS_BYTE_ZERO;
        end else if (NEWER && data_wr) begin
            push_shadow_r <= wdata_in[7:0];
        end
    end

    // pop shadow takes the cell being popped
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pop_shadow_r <= BSS_BYTE_ZERO;
        end else if (NEWER && do_pop && !is_empty) begin
            pop_shadow_r <= cells_r[a_below];
        end
    end

    // ----------------------------------------------------------------
    // sticky flags
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ovf_r <= 1'b0;
        end else if (!NEWER) begin
            if (data_wr && is_full) ovf_r <= 1'b1;
            else if (wr_in && sel_setup && wdata_in[BSS_SETUP_OVF_CLR]) ovf_r <= 1'b0;
        end else begin
            if (do_push && is_full) ovf_r <= 1'b1;
            else if (do_pop) ovf_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            unf_r <= 1'b0;
        end else if (!NEWER) begin
            if (data_rd && is_empty) unf_r <= 1'b1;
            else if (wr_in && sel_setup && wdata_in[BSS_SETUP_UNF_CLR]) unf_r <= 1'b0;
        end else begin
            if (do_pop && is_empty) unf_r <= 1'b1;
            else if (do_push) unf_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [7:0] data_val;
    always_comb begin
        data_val = BSS_BYTE_ZERO;
        if (!NEWER) begin
            if (pop_auto) data_val = cells_r[a_below];
            else if (read_first) data_val = cells_r[a_below];
            else data_val = cells_r[a_top];
        end else begin
            if (pop_auto) begin
                data_val = is_empty ? pop_shadow_r : cells_r[a_below];
            end else if (!read_first || is_empty) begin
                data_val = pop_shadow_r;
            end else begin
                data_val = cells_r[a_below];
            end
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_data) rd_mux[7:0] = data_val;
        if (sel_ctrl) begin
            rd_mux[BSS_CTRL_EMPTY] = is_empty;
            rd_mux[BSS_CTRL_FULL] = is_full;
            rd_mux[BSS_CTRL_OVF] = ovf_r;
            rd_mux[BSS_CTRL_UNF] = unf_r;
        end
        if (sel_setup) rd_mux[2:0] = setup_r;
        if (sel_top) rd_mux[BSS_IDX_W-1:0] = top_r;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 32'h0000_0000;
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= rd_in;
            if (rd_in) rdata_out <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_auto_push_moves: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (data_wr && push_auto && !sel_top && (!NEWER || !is_full)) |=> top_r == $past(top_r) + BSS_IDX_ONE)
        else $error("auto push did not advance index");
    chk_auto_push_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (NEWER && data_wr && push_auto && !is_full) |=>
            cells_r[$past(a_top)] == $past(wdata_in[7:0]))
        else $error("auto push stored wrong byte");
    chk_manual_push_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (data_wr && !push_auto) |=> top_r == $past(top_r))
        else $error("manual push write moved index");
    chk_auto_pop_moves: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (data_rd && pop_auto && !wr_in && !is_empty) |=> top_r == $past(top_r) - BSS_IDX_ONE)
        else $error("auto pop did not retreat index");
    chk_top_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wr_in && sel_top) |=> top_r == $past(wdata_in[9:0]))
        else $error("top index write lost");
    chk_ovf_sets: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (NEWER && do_push && is_full) |=> ovf_r && top_r == $past(top_r))
        else $error("overflow push not discarded");
    chk_unf_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (NEWER && do_push) |=> !unf_r)
        else $error("push did not clear underflow");
    chk_ovf_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (NEWER && do_pop && !(do_push && is_full)) |=> !ovf_r)
        else $error("pop did not clear overflow");
    chk_strobe_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rd_in && sel_ctrl) |=> rvalid_out && rdata_out[1:0] == 2'h0)
        else $error("strobe bits read nonzero");
    chk_unf_legacy: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!NEWER && data_rd && is_empty) |=> unf_r)
        else $error("legacy empty read missed underflow");
endmodule
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import bss_pkg::*;
;
    // ----------------------------------------------------------------
    // signals and design instance
    // ----------------------------------------------------------------
    localparam logic [23:0] A_DAT = BSS_OFF_DATA;
    localparam logic [23:0] A_CTL = BSS_OFF_CTRL;
    localparam logic [23:0] A_SET = BSS_OFF_SETUP;
    localparam logic [23:0] A_TOP = BSS_OFF_TOP;
    logic clk_in;
    logic rst_n_in;
    logic wr_in;
    logic rd_in;
    logic [23:0] addr_in;
    logic [31:0] wdata_in;
    logic [31:0] rdata_out;
    logic rvalid_out;
    int err_total;
    int n_tests;

    bss_stack #(.NEWER(1'b1)) u_bss_stack (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .rdata_out(rdata_out),
        .rvalid_out(rvalid_out)
    );

    // 100 ns clock
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    // verdict and end of run
    task automatic end_of_test;
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        @(posedge clk_in);
        #1;
        wr_in = 1'b1;
        addr_in = a;
        wdata_in = d;
        @(posedge clk_in);
        #1;
        wr_in = 1'b0;
    endtask

    // one-cycle read strobe, bounded wait for the answer, compare
    task automatic rd(input logic [23:0] a, input logic [31:0] ev);
        int i;
        @(posedge clk_in);
        #1;
        rd_in = 1'b1;
        addr_in = a;
        @(posedge clk_in);
        #1;
        rd_in = 1'b0;
        i = 0;
        while (rvalid_out !== 1'b1 && i < 4) begin
            @(posedge clk_in);
            #1;
            i++;
        end
        n_tests++;
        if (i == 4) begin
            err_total++;
            $display("MISMATCH %0t no read answer at %h", $time, a);
            end_of_test();
        end
        if (rdata_out !== ev) begin
            err_total++;
            $display("MISMATCH %0t at %h got %h want %h", $time, a, rdata_out, ev);
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        err_total = 0;
        n_tests = 0;
        rst_n_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 24'h000000;
        wdata_in = 32'h00000000;
        repeat (6) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        rd(A_SET, 32'h00000000);
        rd(A_TOP, 32'h00000000);
        rd(A_CTL, 32'h00000010);
        // manual pushes of two bytes
        wr(A_DAT, 32'h000001A5);
        wr(A_CTL, 32'h00000001);
        wr(A_DAT, 32'h0000003C);
        wr(A_CTL, 32'h00000001);
        rd(A_TOP, 32'h00000002);
        rd(A_DAT, 32'h00000000);
        wr(A_SET, 32'h00000004);
        rd(A_DAT, 32'h0000003C);
        rd(A_TOP, 32'h00000002);
        rd(A_CTL, 32'h00000000);
        // manual pop, then pop-then-fetch read
        wr(A_CTL, 32'h00000002);
        rd(A_TOP, 32'h00000001);
        wr(A_SET, 32'h00000000);
        rd(A_DAT, 32'h0000003C);
        // auto pop with order bit set, then underflow
        wr(A_SET, 32'h00000006);
        rd(A_DAT, 32'h000000A5);
        rd(A_TOP, 32'h00000000);
        rd(A_DAT, 32'h000000A5);
        rd(A_CTL, 32'h00000090);
        // auto push clears underflow, stores the written byte
        wr(A_SET, 32'h00000001);
        wr(A_DAT, 32'h00000077);
        rd(A_CTL, 32'h00000000);
        rd(A_TOP, 32'h00000001);
        wr(A_SET, 32'h00000005);
        rd(A_DAT, 32'h00000077);
        // full stack, refused push, pop clears overflow
        wr(A_TOP, 32'hFFFFF600);
        rd(A_TOP, 32'h00000200);
        rd(A_CTL, 32'h00000020);
        wr(A_CTL, 32'h00000001);
        rd(A_TOP, 32'h00000200);
        rd(A_CTL, 32'h00000060);
        wr(A_CTL, 32'h00000002);
        rd(A_CTL, 32'h00000000);
        rd(A_TOP, 32'h000001FF);
        // clear bits unused here, reserved and unmapped places
        wr(A_SET, 32'h000000C3);
        rd(A_SET, 32'h00000003);
        rd(BSS_OFF_SETUP_LEGACY, 32'h00000000);
        rd(24'h619E50, 32'h00000000);
        end_of_test();
    end
endmodule
`default_nettype wire
